// File: verilog/cdm_pkg.sv
// Purpose: shared constants and types of the carrier data modulator
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   source and carrier inputs travel as packed structs
package cdm_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_MAIN = 16'h0897;
    localparam logic [ADDR_W-1:0] ADDR_CARR_COND = 16'h0898;
    localparam logic [ADDR_W-1:0] ADDR_SRC_CHOICE = 16'h0899;
    localparam logic [ADDR_W-1:0] ADDR_LOW_CHOICE = 16'h089A;
    localparam logic [ADDR_W-1:0] ADDR_HIGH_CHOICE = 16'h089B;
    localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;

    // control register 0 fields
    localparam int BIT_ENABLE = 7;
    localparam int BIT_READBACK = 5;
    localparam int BIT_RESULT_INV = 4;
    localparam int BIT_SW_LEVEL = 0;
    // control register 1 fields
    localparam int BIT_HIGH_INV = 5;
    localparam int BIT_HIGH_WAIT = 4;
    localparam int BIT_LOW_INV = 1;
    localparam int BIT_LOW_WAIT = 0;

    localparam int SRC_SEL_W = 5;
    localparam int CAR_SEL_W = 4;
    localparam logic [SRC_SEL_W-1:0] SRC_CODE_SW = 5'h01;

    typedef struct packed {
        logic       source_pin_route;
        logic [3:0] capture_unit;
        logic [1:0] pulse_width_unit;
        logic       numeric_osc_unit;
        logic [1:0] comparator;
        logic [3:0] logic_cell;
        logic       async_serial_tx;
        logic [1:0] serial_port_sdo;
    } cdm_source_s;

    typedef struct packed {
        logic       high_carrier_pin_route;
        logic       low_carrier_pin_route;
        logic       fast_internal_osc;
        logic       reference_clock_out;
        logic [3:0] capture_unit;
        logic [1:0] pulse_width_unit;
        logic       numeric_osc_unit;
        logic [3:0] logic_cell;
    } cdm_carrier_s;

    localparam int SRC_IN_W = $bits(cdm_source_s);
    localparam int CAR_IN_W = $bits(cdm_carrier_s);

    typedef enum logic {
        CDM_ON_LOW  = 1'b0,
        CDM_ON_HIGH = 1'b1
    } cdm_phase_e;
endpackage

// File: verilog/cdm_sync.sv
// Purpose: two-flop synchroniser bank for outside signals
// Assumes: each bit independent, no bus coherence needed
// Notes:   only the second stage may be read
`timescale 1ns/100ps
`default_nettype none
module cdm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_b,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_clock or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    meta_r[g] <= 1'b0;
                    o_sync[g] <= 1'b0;
                end else begin
                    meta_r[g] <= i_async[g];
                    o_sync[g] <= meta_r[g];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// File: verilog/cdm_pick.sv
// Purpose: one-of-many signal selector
// Assumes: caller ties reserved codes to zero in the vector
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module cdm_pick #(
    parameter int SEL_W = 4
) (
    input  wire logic [(1<<SEL_W)-1:0] i_vec,
    input  wire logic [SEL_W-1:0]      i_sel,
    output var  logic                  o_bit
);
    always_comb begin
        o_bit = i_vec[i_sel];
    end
endmodule
`default_nettype wire

// File: verilog/cdm_modulator.sv
// Purpose: register bank and mixer of the carrier data modulator
// Assumes: all peripheral signals are asynchronous to i_clock
// Notes:   input path adds two cycles, output one more
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cdm_modulator (
    input  wire logic                       i_clock,
    input  wire logic                       i_rst_b,
    input  wire logic [cdm_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [cdm_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    input  wire cdm_pkg::cdm_source_s       i_source,
    input  wire cdm_pkg::cdm_carrier_s      i_carrier,
    output var  logic [cdm_pkg::DATA_W-1:0] o_rdata,
    output var  logic                       o_mod_out
);
    localparam int SYNC_W = cdm_pkg::SRC_IN_W + cdm_pkg::CAR_IN_W;
    localparam int CTRL_KEEP_I = (1 << cdm_pkg::BIT_ENABLE)
                               | (1 << cdm_pkg::BIT_READBACK)
                               | (1 << cdm_pkg::BIT_RESULT_INV)
                               | (1 << cdm_pkg::BIT_SW_LEVEL);
    localparam int COND_KEEP_I = (1 << cdm_pkg::BIT_HIGH_INV)
                               | (1 << cdm_pkg::BIT_HIGH_WAIT)
                               | (1 << cdm_pkg::BIT_LOW_INV)
                               | (1 << cdm_pkg::BIT_LOW_WAIT);

    logic [cdm_pkg::DATA_W-1:0]    ctrl_r, ctrl_nxt;
    logic [cdm_pkg::DATA_W-1:0]    cond_r, cond_nxt;
    logic [cdm_pkg::SRC_SEL_W-1:0] src_sel_r, src_sel_nxt;
    logic [cdm_pkg::CAR_SEL_W-1:0] low_sel_r, low_sel_nxt;
    logic [cdm_pkg::CAR_SEL_W-1:0] high_sel_r, high_sel_nxt;
    logic [cdm_pkg::DATA_W-1:0]    rdata_nxt;
    cdm_pkg::cdm_phase_e           phase_r, phase_nxt;
    logic                          high_prev_r, low_prev_r;
    logic                          sysclk_r, out_r, out_nxt;
    logic [SYNC_W-1:0]             sync_q;
    cdm_pkg::cdm_source_s          src_s;
    cdm_pkg::cdm_carrier_s         car_s;
    logic [(1<<cdm_pkg::SRC_SEL_W)-1:0] src_vec;
    logic [(1<<cdm_pkg::CAR_SEL_W)-1:0] high_vec, low_vec;
    logic src_level, high_raw, low_raw, high_cond, low_cond;
    logic high_fall, low_fall, mixed;
    logic en, res_inv, sw_level, high_inv, high_wait, low_inv, low_wait;

    cdm_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_async ({i_source, i_carrier}),
        .o_sync  (sync_q)
    );

    assign src_s = sync_q[SYNC_W-1:cdm_pkg::CAR_IN_W];
    assign car_s = sync_q[cdm_pkg::CAR_IN_W-1:0];

    assign en        = ctrl_r[cdm_pkg::BIT_ENABLE];
    assign res_inv   = ctrl_r[cdm_pkg::BIT_RESULT_INV];
    assign sw_level  = ctrl_r[cdm_pkg::BIT_SW_LEVEL];
    assign high_inv  = cond_r[cdm_pkg::BIT_HIGH_INV];
    assign high_wait = cond_r[cdm_pkg::BIT_HIGH_WAIT];
    assign low_inv   = cond_r[cdm_pkg::BIT_LOW_INV];
    assign low_wait  = cond_r[cdm_pkg::BIT_LOW_WAIT];

    // index order follows the select codes; reserved codes read zero
    assign src_vec = {14'h0000,
                      src_s.serial_port_sdo,
                      src_s.async_serial_tx,
                      src_s.logic_cell,
                      src_s.comparator,
                      src_s.numeric_osc_unit,
                      src_s.pulse_width_unit,
                      src_s.capture_unit,
                      sw_level,
                      src_s.source_pin_route};

    // system clock cannot be sampled; a half-rate toggle stands in
    assign high_vec = {1'b0,
                       car_s.logic_cell,
                       car_s.numeric_osc_unit,
                       car_s.pulse_width_unit,
                       car_s.capture_unit,
                       car_s.reference_clock_out,
                       car_s.fast_internal_osc,
                       sysclk_r,
                       car_s.high_carrier_pin_route};

    assign low_vec = {high_vec[(1<<cdm_pkg::CAR_SEL_W)-1:1],
                      car_s.low_carrier_pin_route};

    cdm_pick #(
        .SEL_W (cdm_pkg::SRC_SEL_W)
    ) u_pick_src (
        .i_vec (src_vec),
        .i_sel (src_sel_r),
        .o_bit (src_level)
    );

    cdm_pick #(
        .SEL_W (cdm_pkg::CAR_SEL_W)
    ) u_pick_high (
        .i_vec (high_vec),
        .i_sel (high_sel_r),
        .o_bit (high_raw)
    );

    cdm_pick #(
        .SEL_W (cdm_pkg::CAR_SEL_W)
    ) u_pick_low (
        .i_vec (low_vec),
        .i_sel (low_sel_r),
        .o_bit (low_raw)
    );

    assign high_cond = high_raw ^ high_inv;
    assign low_cond  = low_raw ^ low_inv;
    assign high_fall = high_prev_r & ~high_cond;
    assign low_fall  = low_prev_r & ~low_cond;
    assign mixed     = (phase_r == cdm_pkg::CDM_ON_HIGH) ? high_cond
                                                         : low_cond;

    // register file; readback bit is status only, writes to it drop
    always_comb begin
        ctrl_nxt     = ctrl_r;
        cond_nxt     = cond_r;
        src_sel_nxt  = src_sel_r;
        low_sel_nxt  = low_sel_r;
        high_sel_nxt = high_sel_r;
        if (i_wr) begin
            case (i_addr)
                cdm_pkg::ADDR_CTRL_MAIN: begin
                    ctrl_nxt = i_wdata;
                    ctrl_nxt[cdm_pkg::BIT_READBACK] = 1'b0;
                end
                cdm_pkg::ADDR_CARR_COND: begin
                    cond_nxt = i_wdata;
                end
                cdm_pkg::ADDR_SRC_CHOICE: begin
                    src_sel_nxt = i_wdata[cdm_pkg::SRC_SEL_W-1:0];
                end
                cdm_pkg::ADDR_LOW_CHOICE: begin
                    low_sel_nxt = i_wdata[cdm_pkg::CAR_SEL_W-1:0];
                end
                cdm_pkg::ADDR_HIGH_CHOICE: begin
                    high_sel_nxt = i_wdata[cdm_pkg::CAR_SEL_W-1:0];
                end
                default: begin
                    ctrl_nxt = ctrl_r;
                end
            endcase
        end
        // only the documented bits are kept
        ctrl_nxt = ctrl_nxt & CTRL_KEEP_I[cdm_pkg::DATA_W-1:0];
        cond_nxt = cond_nxt & COND_KEEP_I[cdm_pkg::DATA_W-1:0];
    end

    always_comb begin
        rdata_nxt = cdm_pkg::RESET_VALUE;
        if (i_rd) begin
            case (i_addr)
                cdm_pkg::ADDR_CTRL_MAIN: begin
                    rdata_nxt = ctrl_r;
                    rdata_nxt[cdm_pkg::BIT_READBACK] = out_r;
                end
                cdm_pkg::ADDR_CARR_COND: begin
                    rdata_nxt = cond_r;
                end
                cdm_pkg::ADDR_SRC_CHOICE: begin
                    rdata_nxt = {3'h0, src_sel_r};
                end
                cdm_pkg::ADDR_LOW_CHOICE: begin
                    rdata_nxt = {4'h0, low_sel_r};
                end
                cdm_pkg::ADDR_HIGH_CHOICE: begin
                    rdata_nxt = {4'h0, high_sel_r};
                end
                default: begin
                    rdata_nxt = cdm_pkg::RESET_VALUE;
                end
            endcase
        end
    end

    // switching waits for the active carrier to fall when asked to,
    // so the last carrier pulse is never cut short
    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            cdm_pkg::CDM_ON_HIGH: begin
                if (!src_level && (!high_wait || high_fall)) begin
                    phase_nxt = cdm_pkg::CDM_ON_LOW;
                end
            end
            cdm_pkg::CDM_ON_LOW: begin
                if (src_level && (!low_wait || low_fall)) begin
                    phase_nxt = cdm_pkg::CDM_ON_HIGH;
                end
            end
            default: begin
                phase_nxt = cdm_pkg::CDM_ON_LOW;
            end
        endcase
        // selections stay put while off; phase simply follows source
        if (!en) begin
            phase_nxt = src_level ? cdm_pkg::CDM_ON_HIGH
                                  : cdm_pkg::CDM_ON_LOW;
        end
        out_nxt = en ? (mixed ^ res_inv) : 1'b0;
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_r      <= cdm_pkg::RESET_VALUE;
            cond_r      <= cdm_pkg::RESET_VALUE;
            src_sel_r   <= cdm_pkg::RESET_VALUE[cdm_pkg::SRC_SEL_W-1:0];
            low_sel_r   <= cdm_pkg::RESET_VALUE[cdm_pkg::CAR_SEL_W-1:0];
            high_sel_r  <= cdm_pkg::RESET_VALUE[cdm_pkg::CAR_SEL_W-1:0];
            o_rdata     <= cdm_pkg::RESET_VALUE;
            phase_r     <= cdm_pkg::CDM_ON_LOW;
            high_prev_r <= 1'b0;
            low_prev_r  <= 1'b0;
            sysclk_r    <= 1'b0;
            out_r       <= 1'b0;
            o_mod_out   <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            cond_r      <= cond_nxt;
            src_sel_r   <= src_sel_nxt;
            low_sel_r   <= low_sel_nxt;
            high_sel_r  <= high_sel_nxt;
            o_rdata     <= rdata_nxt;
            phase_r     <= phase_nxt;
            high_prev_r <= high_cond;
            low_prev_r  <= low_cond;
            sysclk_r    <= ~sysclk_r;
            out_r       <= out_nxt;
            o_mod_out   <= out_nxt;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    property p_off_low;
        !en |=> !o_mod_out ##1 (!o_mod_out || $past(en));
    endproperty
    a_off_low: assert property (p_off_low)
        else $error("output not low while disabled");

    property p_readback;
        (i_rd && i_addr == cdm_pkg::ADDR_CTRL_MAIN)
            |=> o_rdata[cdm_pkg::BIT_READBACK] == $past(out_r);
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback bit differs from output");

    property p_idle_high;
        (en && res_inv && !mixed) |=> o_mod_out;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("inverted idle output not high");

    property p_sw_source;
        (en && src_sel_r == cdm_pkg::SRC_CODE_SW && !high_wait && !low_wait)
            |=> phase_r == ($past(sw_level) ? cdm_pkg::CDM_ON_HIGH
                                            : cdm_pkg::CDM_ON_LOW);
    endproperty
    a_sw_source: assert property (p_sw_source)
        else $error("software level not followed");

    property p_high_path;
        (en && phase_r == cdm_pkg::CDM_ON_HIGH)
            |=> o_mod_out == ($past(high_raw) ^ $past(high_inv)
                              ^ $past(res_inv));
    endproperty
    a_high_path: assert property (p_high_path)
        else $error("high carrier path wrong");

    property p_low_path;
        (en && phase_r == cdm_pkg::CDM_ON_LOW)
            |=> o_mod_out == ($past(low_raw) ^ $past(low_inv)
                              ^ $past(res_inv));
    endproperty
    a_low_path: assert property (p_low_path)
        else $error("low carrier path wrong");

    property p_high_hold;
        (en && high_wait && phase_r == cdm_pkg::CDM_ON_HIGH && !high_fall)
            |=> phase_r == cdm_pkg::CDM_ON_HIGH;
    endproperty
    a_high_hold: assert property (p_high_hold)
        else $error("left high carrier without falling edge");

    property p_low_hold;
        (en && low_wait && phase_r == cdm_pkg::CDM_ON_LOW && !low_fall)
            |=> phase_r == cdm_pkg::CDM_ON_LOW;
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("left low carrier without falling edge");

    property p_reserved;
        (high_sel_r == 4'hF |-> !high_raw)
            and (low_sel_r == 4'hF |-> !low_raw)
            and (src_sel_r > 5'h11 |-> !src_level);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code passed a signal");

    property p_keep_sel;
        ($fell(en) && !i_wr) |=> $stable(src_sel_r) && $stable(high_sel_r)
                                 && $stable(low_sel_r);
    endproperty
    a_keep_sel: assert property (p_keep_sel)
        else $error("selection lost on disable");

    c_sync_wait: cover property (en && high_wait && high_fall && !src_level
                                 ##1 phase_r == cdm_pkg::CDM_ON_LOW);
    c_sw_mod: cover property (en && src_sel_r == cdm_pkg::SRC_CODE_SW
                              ##1 $rose(o_mod_out));
    c_inverted: cover property (en && res_inv ##1 o_mod_out ##1 !o_mod_out);
endmodule
`default_nettype wire

// File: sim/cdm_far_side.sv
// Purpose: far-side peripheral and pin sources feeding the modulator
// Assumes: bench chooses the levels, model launches them after an edge
// Notes:   registered like real peripheral flops, so no same-edge races
`timescale 1ns/100ps
`default_nettype none
module cdm_far_side (
    input  wire logic                  i_clock,
    input  wire cdm_pkg::cdm_source_s  i_src_lvl,
    input  wire cdm_pkg::cdm_carrier_s i_car_lvl,
    output var  cdm_pkg::cdm_source_s  o_source,
    output var  cdm_pkg::cdm_carrier_s o_carrier
);
    always_ff @(posedge i_clock) begin
        o_source  <= i_src_lvl;
        o_carrier <= i_car_lvl;
    end
endmodule
`default_nettype wire

// File: sim/carrier_data_modulator_regs_test.sv
// Purpose: self-checking bench of the carrier data modulator
// Assumes: static levels settle at the output within eight cycles
// Notes:   carrier code 0001 left out of static checks, it is internal
`timescale 1ns/100ps
`default_nettype none
module carrier_data_modulator_regs_test;
    logic                       i_clock;
    logic                       i_rst_b;
    logic [cdm_pkg::ADDR_W-1:0] i_addr;
    logic [cdm_pkg::DATA_W-1:0] i_wdata;
    logic                       i_wr;
    logic                       i_rd;
    logic [cdm_pkg::DATA_W-1:0] o_rdata;
    logic                       o_mod_out;
    cdm_pkg::cdm_source_s       src_lvl;
    cdm_pkg::cdm_source_s       source;
    cdm_pkg::cdm_carrier_s      car_lvl;
    cdm_pkg::cdm_carrier_s      carrier;
    int                         error_cnt;
    int                         n_checks;
    logic [7:0]                 rd_val;
    logic                       prev_out;
    logic [7:0]                 cfg [5];
    logic [7:0]                 keep [5] = '{8'h11, 8'h33, 8'h1F, 8'h0F, 8'h0F};

    cdm_modulator cdm_modulator_inst (
        .i_clock   (i_clock),
        .i_rst_b   (i_rst_b),
        .i_addr    (i_addr),
        .i_wdata   (i_wdata),
        .i_wr      (i_wr),
        .i_rd      (i_rd),
        .i_source  (source),
        .i_carrier (carrier),
        .o_rdata   (o_rdata),
        .o_mod_out (o_mod_out)
    );

    cdm_far_side cdm_far_side_inst (
        .i_clock   (i_clock),
        .i_src_lvl (src_lvl),
        .i_car_lvl (car_lvl),
        .o_source  (source),
        .o_carrier (carrier)
    );

    always #50 i_clock = ~i_clock;

    function automatic logic pick_src(input logic [4:0] c);
        case (c) inside
            5'h00:          return src_lvl.source_pin_route;
            5'h01:          return cfg[0][0];
            [5'h02:5'h05]:  return src_lvl.capture_unit[c - 5'h02];
            [5'h06:5'h07]:  return src_lvl.pulse_width_unit[c - 5'h06];
            5'h08:          return src_lvl.numeric_osc_unit;
            [5'h09:5'h0A]:  return src_lvl.comparator[c - 5'h09];
            [5'h0B:5'h0E]:  return src_lvl.logic_cell[c - 5'h0B];
            5'h0F:          return src_lvl.async_serial_tx;
            [5'h10:5'h11]:  return src_lvl.serial_port_sdo[c - 5'h10];
            default:        return 1'b0;
        endcase
    endfunction

    function automatic logic pick_car(input logic [3:0] c, input logic hi);
        case (c) inside
            4'h0:          return hi ? car_lvl.high_carrier_pin_route
                                     : car_lvl.low_carrier_pin_route;
            4'h2:          return car_lvl.fast_internal_osc;
            4'h3:          return car_lvl.reference_clock_out;
            [4'h4:4'h7]:   return car_lvl.capture_unit[c - 4'h4];
            [4'h8:4'h9]:   return car_lvl.pulse_width_unit[c - 4'h8];
            4'hA:          return car_lvl.numeric_osc_unit;
            [4'hB:4'hE]:   return car_lvl.logic_cell[c - 4'hB];
            default:       return 1'b0;
        endcase
    endfunction

    function automatic logic exp_out();
        logic hi;
        logic lo;
        hi = pick_car(cfg[4][3:0], 1'b1) ^ cfg[1][5];
        lo = pick_car(cfg[3][3:0], 1'b0) ^ cfg[1][1];
        if (!cfg[0][7]) begin
            return 1'b0;
        end
        return (pick_src(cfg[2][4:0]) ? hi : lo) ^ cfg[0][4];
    endfunction

    task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_out(input logic e);
        n_checks++;
        if (o_mod_out !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, o_mod_out);
        end
    endtask

    task automatic wr(input int i, input logic [7:0] d);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= cdm_pkg::ADDR_CTRL_MAIN + 16'(i);
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input int i);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= cdm_pkg::ADDR_CTRL_MAIN + 16'(i);
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        rd_val = o_rdata;
    endtask

    task automatic settle();
        repeat (8) @(posedge i_clock);
        @(negedge i_clock);
    endtask

    task automatic results();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clock);
        error_cnt++;
        results();
    end

    initial begin
        int                    k;
        logic [31:0]           r;
        cdm_pkg::cdm_carrier_s c;
        i_clock   = 1'b0;
        i_rst_b   = 1'b0;
        i_addr    = '0;
        i_wdata   = '0;
        i_wr      = 1'b0;
        i_rd      = 1'b0;
        src_lvl   = '0;
        car_lvl   = '0;
        error_cnt = 0;
        n_checks  = 0;
        r = $urandom(3);
        repeat (4) @(posedge i_clock);
        @(negedge i_clock);
        chk_out(1'b0);
        @(posedge i_clock);
        i_rst_b <= 1'b1;
        for (k = 0; k < 5; k++) begin
            rd(k);
            chk_reg(8'h00, rd_val);
            wr(k, (k == 0) ? 8'h5F : 8'hFF);
            rd(k);
            chk_reg(keep[k], rd_val);
        end
        wr(5, 8'hFF);
        rd(5);
        chk_reg(8'h00, rd_val);
        rd(-1);
        chk_reg(8'h00, rd_val);
        // source codes 00 to 13h and every carrier code but 0001, random levels and polarities, no edge wait
        for (k = 0; k < 40; k++) begin
            r = $urandom;
            cfg[0] = (r[7:0] & 8'h11) | 8'h80;
            cfg[1] = r[15:8] & 8'h22;
            cfg[2] = 8'(k % 20);
            cfg[4] = (k % 16 == 1) ? 8'h00 : 8'(k % 16);
            cfg[3] = ((k + 7) % 16 == 1) ? 8'h0F : 8'((k + 7) % 16);
            @(posedge i_clock);
            r = $urandom;
            src_lvl <= r[cdm_pkg::SRC_IN_W-1:0];
            r = $urandom;
            car_lvl <= r[cdm_pkg::CAR_IN_W-1:0];
            for (int i = 4; i >= 0; i--) begin
                wr(i, cfg[i]);
            end
            settle();
            chk_out(exp_out());
            rd(0);
            chk_reg({cfg[0][7], 1'b0, exp_out(), cfg[0][4], 3'b000, cfg[0][0]}, rd_val);
            wr(0, cfg[0] & 8'h7F);
            settle();
            chk_out(1'b0);
            rd(2);
            chk_reg(cfg[2], rd_val);
        end
        wr(2, {3'b000, cdm_pkg::SRC_CODE_SW});
        wr(3, 8'h00);
        wr(4, 8'h00);
        // active carrier held high: switch must wait for its fall
        for (k = 0; k < 2; k++) begin
            wr(1, (k == 1) ? 8'h01 : 8'h10);
            c = '0;
            c.high_carrier_pin_route = (k == 0);
            c.low_carrier_pin_route = (k == 1);
            @(posedge i_clock);
            car_lvl <= c;
            wr(0, (k == 1) ? 8'h00 : 8'h01);
            wr(0, (k == 1) ? 8'h80 : 8'h81);
            settle();
            chk_out(1'b1);
            wr(0, (k == 1) ? 8'h81 : 8'h80);
            repeat (10) begin
                @(negedge i_clock);
                chk_out(1'b1);
            end
            @(posedge i_clock);
            car_lvl <= ~c;
            settle();
            chk_out(1'b1);
        end
        // system clock carrier shows as a toggle at every rising edge
        wr(1, 8'h00);
        wr(3, 8'h01);
        wr(4, 8'h01);
        for (k = 0; k < 2; k++) begin
            wr(0, (k == 1) ? 8'h80 : 8'h81);
            settle();
            repeat (6) begin
                prev_out = o_mod_out;
                @(negedge i_clock);
                chk_out(~prev_out);
            end
        end
        // reset in mid-run while the output toggles
        @(posedge i_clock);
        i_rst_b <= 1'b0;
        @(negedge i_clock);
        chk_out(1'b0);
        @(posedge i_clock);
        i_rst_b <= 1'b1;
        for (k = 0; k < 5; k++) begin
            rd(k);
            chk_reg(8'h00, rd_val);
        end
        results();
    end
endmodule
`default_nettype wire
